// ---- rtl/phy_pins_defs.svh ----
// register offsets, field positions and reset values of the pin control block
`ifndef PHY_PINS_DEFS_SVH
`define PHY_PINS_DEFS_SVH
// register indices, byte address is four times the index
`define IDX_BASIC 6'h00
`define IDX_STRAP 6'h10
`define IDX_IRQ_STAT 6'h1b
`define IDX_IRQ_MASK 6'h1c
`define IDX_TX_NIB 6'h1d
`define IDX_LED_CTRL 6'h1e
`define IDX_PHY_CTRL2 6'h1f
// field positions
`define BIT_ANEG 12
`define BIT_ISOLATE 10
`define BIT_IRQ_POL 9
`define LED_MODE_HI 15
`define LED_MODE_LO 14
`define IRQ_LINK_UP 0
`define IRQ_LINK_DOWN 1
`define IRQ_RX_ERR 2
`define IRQ_COLLISION 3
`define IRQ_TX_START 4
// widths and reset values
`define IRQ_W 5
`define STRAP_W 4
`define RD_UNMAPPED 32'h0000_0000
`define POL_RESET 1'b0
`define LED_MODE_RESET 2'h0
`define IRQ_MASK_RESET 5'h00
`define STRAP_RESET 4'h0
`endif

// ---- rtl/phy_pins_pkg.sv ----
// types shared by the dual-function pin control block
package phy_pins_pkg;
  // captured strap levels, order matches the strap status register
  typedef struct packed {
    logic autoneg;
    logic isolate;
    logic cfg1;
    logic cfg0;
  } strap_s;
  // indicator pin modes
  typedef enum logic [1:0] {
    LED_LINK_ACT = 2'h0,
    LED_LINK = 2'h1,
    LED_RSV2 = 2'h2,
    LED_RSV3 = 2'h3
  } led_mode_e;
  // strap capture sequencing
  typedef enum logic [1:0] {
    ST_STRAP = 2'h1,
    ST_RUN = 2'h2
  } boot_e;
  // one gathered transmit nibble
  typedef struct packed {
    logic [3:0] data;
    logic valid;
  } tx_nib_s;
endpackage : phy_pins_pkg

// ---- rtl/tx_gather.sv ----
// transmit enable and data capture, four bits per beat in mii, two in rmii
`timescale 1ns/1ps
module tx_gather (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // mode and mac side pins
  input wire logic i_rmii,
  input wire logic i_tx_en,
  input wire logic [3:0] i_txd,
  // gathered data
  output phy_pins_pkg::tx_nib_s o_nib,
  output logic o_start
);
  phy_pins_pkg::tx_nib_s nib_r;
  logic half_r;
  logic [1:0] low_r;
  logic en_d_r;
  // rmii pairs dibits low first; mii takes the nibble whole
  wire [3:0] data_nxt = i_rmii ? {i_txd[1:0], low_r} : i_txd;
  wire valid_nxt = i_tx_en & (~i_rmii | half_r);
  // data lines are ignored whenever enable is low
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      nib_r <= '0;
      half_r <= 1'b0;
      low_r <= 2'h0;
      en_d_r <= 1'b0;
    end else begin
      nib_r.valid <= valid_nxt;
      if (valid_nxt) nib_r.data <= data_nxt;
      // an odd dibit at frame end is dropped with the half flag
      half_r <= i_rmii & i_tx_en & ~half_r;
      if (i_rmii & i_tx_en) low_r <= i_txd[1:0];
      en_d_r <= i_tx_en;
    end
  end
  assign o_nib = nib_r;
  assign o_start = i_tx_en & ~en_d_r;
endmodule : tx_gather

// ---- rtl/led_drive.sv ----
// indicator pin level generator for link and activity
`timescale 1ns/1ps
module led_drive (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // mode and line state
  input phy_pins_pkg::led_mode_e i_mode,
  input wire logic i_link,
  input wire logic i_activity,
  // pin level, high is off
  output logic o_level
);
  logic blink_r;
  logic level_r;
  // activity toggles only while linked, so a dropped link starts clean
  wire blink_nxt = i_link & (blink_r ^ i_activity);
  // reserved modes keep the indicator dark
  wire level_nxt = (i_mode == phy_pins_pkg::LED_LINK_ACT) ? (~i_link | blink_nxt) :
                   (i_mode == phy_pins_pkg::LED_LINK) ? ~i_link : 1'b1;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      blink_r <= 1'b0;
      level_r <= 1'b1;
    end else begin
      blink_r <= blink_nxt;
      level_r <= level_nxt;
    end
  end
  assign o_level = level_r;
endmodule : led_drive

// ---- rtl/phy_pin_ctrl.sv ----
// dual-function pin control of the transceiver with an avalon-mm register slave
//
// Function
// - strap the receive-error pin as isolate at reset; afterwards drive receive error.
// - interrupt pin polarity follows bit 9 of register 1Fh, low active by default.
// - interrupt status and mask registers select and report interrupt causes.
// - register 1Eh bits 15:14 set indicator mode; 00 link/activity, 01 link only.
// - strap the indicator pin into auto-negotiation enable, register 0h bit 12.
// - strap the collision pin as config bit 0; afterwards drive collision in mii.
// - strap the carrier pin as config bit 1; afterwards drive carrier sense in mii.
// - mii transmit takes four data bits while enable is high, ignores them otherwise.
// - rmii transmit takes two data bits per clock while enable is high.
// - strap pins are inputs during reset and the capture cycle after it, outputs otherwise; isolate frees all but the indicator, rmii frees col and crs.
//
// The placing of the registers and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
`include "phy_pins_defs.svh"
module phy_pin_ctrl (
  // clock and reset
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  // avalon-mm register slave
  input wire logic [7:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  output logic O_IRQ,
  // line state from the transceiver core
  input wire logic I_LINK_UP,
  input wire logic I_ACTIVITY,
  input wire logic I_RX_ERR,
  input wire logic I_CORE_COLLISION,
  input wire logic I_CORE_CARRIER,
  input wire logic I_RMII_MODE,
  // receive error pin, isolate strap
  input wire logic I_RECEIVE_ERROR_OUT,
  output logic O_RECEIVE_ERROR_OUT,
  output logic O_RECEIVE_ERROR_OUT_OE_N,
  // collision pin, config bit zero strap
  input wire logic I_COLLISION_PIN,
  output logic O_COLLISION_PIN,
  output logic O_COLLISION_PIN_OE_N,
  // carrier sense pin, config bit one strap
  input wire logic I_CARRIER_PIN,
  output logic O_CARRIER_PIN,
  output logic O_CARRIER_PIN_OE_N,
  // indicator pin, auto-negotiation strap
  input wire logic I_INDICATOR_ZERO_PIN,
  output logic O_INDICATOR_ZERO_PIN,
  output logic O_INDICATOR_ZERO_PIN_OE_N,
  // interrupt pin
  output logic O_IRQ_PIN,
  // mac transmit pins
  input wire logic I_TRANSMIT_ENABLE_IN,
  input wire logic [3:0] I_TXD,
  // transmit data towards the core
  output logic [3:0] O_TX_NIBBLE,
  output logic O_TX_NIBBLE_VALID,
  // strap results towards the core
  output logic [1:0] O_CFG_STRAP,
  output logic O_ISOLATE,
  output logic O_AUTONEG_EN
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------

  // merge write data into a word under the byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old_w,
                                           input logic [31:0] new_w,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) res[i*8 +: 8] = new_w[i*8 +: 8];
    end
    return res;
  endfunction : be_merge

  // ----------------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------------

  phy_pins_pkg::boot_e state_r;
  phy_pins_pkg::boot_e state_nxt;
  phy_pins_pkg::strap_s strap_r;
  phy_pins_pkg::strap_s strap_nxt;
  logic run;

  // the pins sit undriven through reset, so the first edge after release
  // sees only the board pulls
  assign strap_nxt = '{autoneg: I_INDICATOR_ZERO_PIN, isolate: I_RECEIVE_ERROR_OUT,
                       cfg1: I_CARRIER_PIN, cfg0: I_COLLISION_PIN};
  assign run = (state_r == phy_pins_pkg::ST_RUN);

  // one capture then run until the next reset
  always_comb begin
    unique case (state_r)
      phy_pins_pkg::ST_STRAP: state_nxt = phy_pins_pkg::ST_RUN;
      phy_pins_pkg::ST_RUN: state_nxt = phy_pins_pkg::ST_RUN;
      default: state_nxt = phy_pins_pkg::ST_STRAP;
    endcase
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_r <= phy_pins_pkg::ST_STRAP;
      strap_r <= `STRAP_RESET;
    end else begin
      state_r <= state_nxt;
      if (state_r == phy_pins_pkg::ST_STRAP) strap_r <= strap_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // avalon-mm slave
  // ----------------------------------------------------------------------

  logic ack_r;
  logic [31:0] rdata_r;
  logic [5:0] idx;
  logic req;
  logic ack_nxt;
  logic wr_fire;
  logic [31:0] rd_word;

  // one wait state per access, held off entirely until straps are in
  assign idx = I_AVS_ADDRESS[7:2];
  assign req = I_AVS_READ | I_AVS_WRITE;
  assign ack_nxt = req & ~ack_r & run;
  assign wr_fire = I_AVS_WRITE & ack_r;
  assign O_AVS_WAITREQUEST = req & ~ack_r;

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------

  logic aneg_r;
  logic iso_r;
  logic pol_r;
  phy_pins_pkg::led_mode_e led_mode_r;
  logic [`IRQ_W-1:0] mask_r;
  logic [`IRQ_W-1:0] stat_r;
  logic [31:0] basic_word;
  logic [31:0] basic_new;
  logic [31:0] led_new;
  logic [31:0] ctrl2_new;
  logic [31:0] mask_new;
  logic [31:0] clr_word;
  logic wr_basic;
  logic wr_led;
  logic wr_ctrl2;
  logic wr_mask;
  logic wr_stat;

  assign wr_basic = wr_fire & (idx == `IDX_BASIC);
  assign wr_led = wr_fire & (idx == `IDX_LED_CTRL);
  assign wr_ctrl2 = wr_fire & (idx == `IDX_PHY_CTRL2);
  assign wr_mask = wr_fire & (idx == `IDX_IRQ_MASK);
  assign wr_stat = wr_fire & (idx == `IDX_IRQ_STAT);

  // byte-lane merge keeps untouched fields when a lane is not enabled
  assign basic_word = (32'(aneg_r) << `BIT_ANEG) | (32'(iso_r) << `BIT_ISOLATE);
  assign basic_new = be_merge(basic_word, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
  assign led_new = be_merge(32'(led_mode_r) << `LED_MODE_LO, I_AVS_WRITEDATA,
                            I_AVS_BYTEENABLE);
  assign ctrl2_new = be_merge(32'(pol_r) << `BIT_IRQ_POL, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
  assign mask_new = be_merge(32'(mask_r), I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
  assign clr_word = be_merge(32'h0000_0000, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);

  // basic control loads its strap values at capture, software may override
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      aneg_r <= 1'b0;
      iso_r <= 1'b0;
    end else if (state_r == phy_pins_pkg::ST_STRAP) begin
      aneg_r <= strap_nxt.autoneg;
      iso_r <= strap_nxt.isolate;
    end else if (wr_basic) begin
      aneg_r <= basic_new[`BIT_ANEG];
      iso_r <= basic_new[`BIT_ISOLATE];
    end
  end

  // mode, polarity and mask registers
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      led_mode_r <= phy_pins_pkg::led_mode_e'(`LED_MODE_RESET);
      pol_r <= `POL_RESET;
      mask_r <= `IRQ_MASK_RESET;
    end else begin
      if (wr_led) led_mode_r <= phy_pins_pkg::led_mode_e'(led_new[`LED_MODE_HI:`LED_MODE_LO]);
      if (wr_ctrl2) pol_r <= ctrl2_new[`BIT_IRQ_POL];
      if (wr_mask) mask_r <= mask_new[`IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // interrupt events
  // ----------------------------------------------------------------------

  logic link_d_r;
  logic [`IRQ_W-1:0] ev;
  logic [`IRQ_W-1:0] stat_nxt;
  logic irq_pin_r;
  logic tx_start;

  assign ev[`IRQ_LINK_UP] = I_LINK_UP & ~link_d_r;
  assign ev[`IRQ_LINK_DOWN] = ~I_LINK_UP & link_d_r;
  assign ev[`IRQ_RX_ERR] = I_RX_ERR & run;
  assign ev[`IRQ_COLLISION] = I_CORE_COLLISION & run;
  assign ev[`IRQ_TX_START] = tx_start & run;
  // write one to clear, a new event in the same cycle wins
  assign stat_nxt = (stat_r & ~(wr_stat ? clr_word[`IRQ_W-1:0] : '0)) | ev;
  assign O_IRQ = |(stat_r & mask_r);

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      link_d_r <= 1'b0;
      stat_r <= '0;
      irq_pin_r <= 1'b1;
    end else begin
      link_d_r <= I_LINK_UP;
      stat_r <= stat_nxt;
      irq_pin_r <= pol_r ? O_IRQ : ~O_IRQ;
    end
  end
  assign O_IRQ_PIN = irq_pin_r;

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------

  phy_pins_pkg::tx_nib_s nib;

  // unmapped indices read zero and still complete
  assign rd_word = (idx == `IDX_BASIC) ? basic_word :
                   (idx == `IDX_STRAP) ? 32'(strap_r) :
                   (idx == `IDX_IRQ_STAT) ? 32'(stat_r) :
                   (idx == `IDX_IRQ_MASK) ? 32'(mask_r) :
                   (idx == `IDX_TX_NIB) ? 32'(nib.data) :
                   (idx == `IDX_LED_CTRL) ? (32'(led_mode_r) << `LED_MODE_LO) :
                   (idx == `IDX_PHY_CTRL2) ? (32'(pol_r) << `BIT_IRQ_POL) :
                   `RD_UNMAPPED;

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ack_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      ack_r <= ack_nxt;
      if (ack_nxt & I_AVS_READ) rdata_r <= rd_word;
    end
  end
  assign O_AVS_READDATA = rdata_r;

  // ----------------------------------------------------------------------
  // pin outputs
  // ----------------------------------------------------------------------

  logic rxerr_r;
  logic col_r;
  logic crs_r;
  logic led_level;

  // isolate releases the mac-facing outputs, indicator stays driven
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rxerr_r <= 1'b0;
      col_r <= 1'b0;
      crs_r <= 1'b0;
    end else begin
      rxerr_r <= I_RX_ERR;
      col_r <= I_CORE_COLLISION;
      crs_r <= I_CORE_CARRIER;
    end
  end

  led_drive u_led (
    .i_clk(I_MCLK),
    .i_rst_n(I_RST_N),
    .i_mode(led_mode_r),
    .i_link(I_LINK_UP),
    .i_activity(I_ACTIVITY),
    .o_level(led_level)
  );

  // enables stay off until capture; col and crs carry nothing in rmii
  assign O_RECEIVE_ERROR_OUT = rxerr_r;
  assign O_RECEIVE_ERROR_OUT_OE_N = ~run | iso_r;
  assign O_COLLISION_PIN = col_r;
  assign O_COLLISION_PIN_OE_N = ~run | iso_r | I_RMII_MODE;
  assign O_CARRIER_PIN = crs_r;
  assign O_CARRIER_PIN_OE_N = ~run | iso_r | I_RMII_MODE;
  assign O_INDICATOR_ZERO_PIN = led_level;
  assign O_INDICATOR_ZERO_PIN_OE_N = ~run;

  // ----------------------------------------------------------------------
  // transmit capture
  // ----------------------------------------------------------------------

  tx_gather u_tx (
    .i_clk(I_MCLK),
    .i_rst_n(I_RST_N),
    .i_rmii(I_RMII_MODE),
    .i_tx_en(I_TRANSMIT_ENABLE_IN),
    .i_txd(I_TXD),
    .o_nib(nib),
    .o_start(tx_start)
  );

  assign O_TX_NIBBLE = nib.data;
  assign O_TX_NIBBLE_VALID = nib.valid;
  assign O_CFG_STRAP = {strap_r.cfg1, strap_r.cfg0};
  assign O_ISOLATE = iso_r;
  assign O_AUTONEG_EN = aneg_r;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------

  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RST_N);

  AST_ISO_STRAP: assert property (
    state_r == phy_pins_pkg::ST_STRAP |=> strap_r.isolate == $past(I_RECEIVE_ERROR_OUT)
  ) else $error("isolate strap not taken from receive error pin");

  AST_IRQ_POLARITY: assert property (
    ##1 O_IRQ_PIN == ($past(pol_r) ? $past(O_IRQ) : !$past(O_IRQ))
  ) else $error("interrupt pin polarity wrong");

  AST_IRQ_STICKY: assert property (
    ev[`IRQ_RX_ERR] |=> stat_r[`IRQ_RX_ERR] && (!mask_r[`IRQ_RX_ERR] || O_IRQ)
  ) else $error("receive error event not latched");

  AST_LED_LINK_ONLY: assert property (
    (led_mode_r == phy_pins_pkg::LED_LINK && !I_LINK_UP) [*2] |-> O_INDICATOR_ZERO_PIN
  ) else $error("indicator not off without link");

  AST_ANEG_STRAP: assert property (
    state_r == phy_pins_pkg::ST_STRAP |=> aneg_r == $past(I_INDICATOR_ZERO_PIN)
  ) else $error("auto-negotiation strap wrong");

  AST_CFG0_STRAP: assert property (
    state_r == phy_pins_pkg::ST_STRAP |=> strap_r.cfg0 == $past(I_COLLISION_PIN)
  ) else $error("config bit zero strap wrong");

  AST_CFG1_STRAP: assert property (
    state_r == phy_pins_pkg::ST_STRAP |=> strap_r.cfg1 == $past(I_CARRIER_PIN)
  ) else $error("config bit one strap wrong");

  AST_MII_IGNORE: assert property (
    !I_TRANSMIT_ENABLE_IN |=> !O_TX_NIBBLE_VALID
  ) else $error("transmit data taken while enable low");

  AST_RMII_PAIR: assert property (
    O_TX_NIBBLE_VALID && $past(I_RMII_MODE) |->
      $past(I_TRANSMIT_ENABLE_IN, 1) && $past(I_TRANSMIT_ENABLE_IN, 2)
  ) else $error("rmii nibble without two enabled beats");

  AST_STRAP_INPUT: assert property (
    state_r == phy_pins_pkg::ST_STRAP |->
      O_RECEIVE_ERROR_OUT_OE_N && O_COLLISION_PIN_OE_N && O_CARRIER_PIN_OE_N &&
      O_INDICATOR_ZERO_PIN_OE_N
  ) else $error("strap pin driven before capture");

  AST_STRAP_HOLD: assert property (
    run |=> $stable(strap_r) && run
  ) else $error("strap values changed after capture");

endmodule : phy_pin_ctrl

// ---- sim/mac_model.sv ----
// mac side model driving transmit enable and data into the pin block
`timescale 1ns/1ps
module mac_model (
  // clock and mode
  input wire logic i_clk,
  input wire logic i_rmii,
  // transmit pins
  output logic o_tx_en,
  output logic [3:0] o_txd
);
  // idle: enable low, data lines carry junk the block must ignore
  initial begin
    o_tx_en = 1'b0;
    o_txd = 4'h5;
  end
  // one nibble: a single beat in mii, low then high dibit in rmii
  task automatic send(input logic [3:0] nib);
    @(posedge i_clk);
    o_tx_en <= 1'b1;
    if (i_rmii) begin
      o_txd <= {~nib[3:2], nib[1:0]};
      @(posedge i_clk);
      o_txd <= {~nib[1:0], nib[3:2]};
    end else begin
      o_txd <= nib;
    end
    @(posedge i_clk);
    o_tx_en <= 1'b0;
    // released lines show the inverse so a stale value cannot pass
    o_txd <= ~nib;
  endtask : send
endmodule : mac_model

// ---- sim/tb.sv ----
// self-checking bench for the dual-function pin control block
`timescale 1ns/1ps
`include "phy_pins_defs.svh"
module tb;
  // ----------------------------------------
  // stimulus, pins and counters
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic link = 1'b0, activity = 1'b0, rx_err = 1'b0, core_col = 1'b0, core_crs = 1'b0;
  logic rmii = 1'b0;
  logic [3:0] strap = 4'h9; // board pulls {autoneg, isolate, cfg1, cfg0}
  wire [31:0] readdata;
  wire waitreq, irq, irq_pin, tx_en, nib_v, iso, aneg;
  wire rerr_o, rerr_oe_n, col_o, col_oe_n, crs_o, crs_oe_n, led_o, led_oe_n;
  wire [3:0] txd, nib;
  wire [1:0] cfg;
  // pin level: pull while the block listens, its own drive otherwise
  wire pin_rerr = rerr_oe_n ? strap[2] : rerr_o;
  wire pin_col = col_oe_n ? strap[0] : col_o;
  wire pin_crs = crs_oe_n ? strap[1] : crs_o;
  wire pin_led = led_oe_n ? strap[3] : led_o;
  int error_cnt = 0;
  int checks_done = 0;

  always #2.5 clk = ~clk;

  phy_pin_ctrl i_dut (.I_MCLK(clk), .I_RST_N(rst_n), .I_AVS_ADDRESS(address),
    .I_AVS_READ(read), .I_AVS_WRITE(write), .I_AVS_WRITEDATA(writedata),
    .I_AVS_BYTEENABLE(4'hf), .O_AVS_READDATA(readdata), .O_AVS_WAITREQUEST(waitreq),
    .O_IRQ(irq), .I_LINK_UP(link), .I_ACTIVITY(activity), .I_RX_ERR(rx_err),
    .I_CORE_COLLISION(core_col), .I_CORE_CARRIER(core_crs), .I_RMII_MODE(rmii),
    .I_RECEIVE_ERROR_OUT(pin_rerr), .O_RECEIVE_ERROR_OUT(rerr_o),
    .O_RECEIVE_ERROR_OUT_OE_N(rerr_oe_n), .I_COLLISION_PIN(pin_col),
    .O_COLLISION_PIN(col_o), .O_COLLISION_PIN_OE_N(col_oe_n), .I_CARRIER_PIN(pin_crs),
    .O_CARRIER_PIN(crs_o), .O_CARRIER_PIN_OE_N(crs_oe_n),
    .I_INDICATOR_ZERO_PIN(pin_led), .O_INDICATOR_ZERO_PIN(led_o),
    .O_INDICATOR_ZERO_PIN_OE_N(led_oe_n), .O_IRQ_PIN(irq_pin),
    .I_TRANSMIT_ENABLE_IN(tx_en), .I_TXD(txd), .O_TX_NIBBLE(nib),
    .O_TX_NIBBLE_VALID(nib_v), .O_CFG_STRAP(cfg), .O_ISOLATE(iso), .O_AUTONEG_EN(aneg));

  mac_model i_mac (.i_clk(clk), .i_rmii(rmii), .o_tx_en(tx_en), .o_txd(txd));

  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  // bus cycles hold the request until waitrequest is seen low at an edge
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    do @(posedge clk); while (waitreq !== 1'b0);
    write <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    address <= a;
    read <= 1'b1;
    do @(posedge clk); while (waitreq !== 1'b0);
    d = readdata;
    read <= 1'b0;
  endtask : bus_rd

  // reset with given pull levels, held across the capture edge
  task automatic do_reset(input logic [3:0] s);
    @(posedge clk);
    rst_n <= 1'b0;
    strap <= s;
    repeat (2) @(posedge clk);
    #1;
    chk("oe_n in reset", {rerr_oe_n, col_oe_n, crs_oe_n, led_oe_n}, 4'hf);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask : do_reset

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_strap;
    logic [31:0] d;
    logic [3:0] s;
    for (int i = 0; i < 2; i++) begin
      s = (i == 0) ? 4'h6 : 4'h9;
      do_reset(s);
      chk("cfg strap", cfg, s[1:0]);
      chk("isolate", iso, s[2]);
      chk("autoneg", aneg, s[3]);
      chk("rerr oe_n", rerr_oe_n, s[2]);
      chk("col oe_n", col_oe_n, s[2]);
      chk("led oe_n", led_oe_n, 1'b0);
      @(posedge clk);
      strap <= ~s; // pull levels move after capture
      bus_rd(8'h40, d);
      chk("strap status", d, {28'h0, s});
      bus_wr(8'h40, 32'h0);
      bus_rd(8'h40, d);
      chk("strap status read only", d, {28'h0, s});
      bus_rd(8'h00, d);
      chk("basic aneg iso", {d[12], d[10]}, {s[3], s[2]});
    end
    // drive levels opposite to the pulls so a floating pin shows
    @(posedge clk);
    core_col <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("rerr pin", pin_rerr, 1'b0);
    chk("col pin", pin_col, 1'b1);
    chk("crs pin", pin_crs, 1'b0);
    // swap the two core levels so each pin is seen following its source
    @(posedge clk);
    core_col <= 1'b0;
    core_crs <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("crs follows", pin_crs, 1'b1);
    chk("col follows", pin_col, 1'b0);
    @(posedge clk);
    core_crs <= 1'b0;
    $display("strap test done");
  endtask : t_strap

  task automatic t_irq;
    logic [31:0] d;
    bus_rd(8'h70, d);
    chk("mask reset", d, 32'h0);
    bus_rd(8'h7c, d);
    chk("polarity reset", d[9], 1'b0);
    bus_wr(8'h6c, 32'h1f);
    bus_wr(8'h70, 32'h1 << `IRQ_LINK_UP);
    @(posedge clk);
    link <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("irq", irq, 1'b1);
    chk("irq pin low active", irq_pin, 1'b0);
    @(posedge clk);
    link <= 1'b0;
    bus_rd(8'h6c, d);
    chk("status both link", d[1:0], 2'h3);
    bus_wr(8'h7c, 32'h1 << `BIT_IRQ_POL);
    repeat (2) @(posedge clk);
    #1;
    chk("irq pin high active", irq_pin, 1'b1);
    bus_wr(8'h6c, 32'h1 << `IRQ_LINK_UP);
    bus_rd(8'h6c, d);
    chk("status after clear", d[1:0], 2'h2);
    repeat (2) @(posedge clk);
    #1;
    chk("masked irq", irq, 1'b0);
    chk("irq pin idle", irq_pin, 1'b0);
    // one receive error pulse: pin copy one cycle late, status bit sticks
    @(posedge clk);
    rx_err <= 1'b1;
    @(posedge clk);
    rx_err <= 1'b0;
    #1;
    chk("rerr follows", pin_rerr, 1'b1);
    bus_rd(8'h6c, d);
    chk("status rx error", d[`IRQ_RX_ERR], 1'b1);
    bus_rd(8'h20, d);
    chk("unmapped read", d, 32'h0);
    $display("interrupt test done");
  endtask : t_irq

  task automatic t_led;
    for (int m = 0; m < 4; m++) begin
      for (int l = 0; l < 2; l++) begin
        bus_wr(8'h78, 32'(m) << `LED_MODE_LO);
        @(posedge clk);
        link <= l[0];
        repeat (3) @(posedge clk);
        #1;
        chk("indicator", pin_led, (m < 2) ? 32'(!l[0]) : 32'h1);
      end
    end
    // link is up now; each activity pulse flips the pin in mode 00
    bus_wr(8'h78, 32'h0);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      activity <= 1'b1;
      @(posedge clk);
      activity <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("indicator toggle", pin_led, (k == 0) ? 32'h1 : 32'h0);
    end
    $display("indicator test done");
  endtask : t_led

  task automatic t_tx;
    logic [31:0] d;
    i_mac.send(4'ha);
    #1;
    chk("mii valid", nib_v, 1'b1);
    chk("mii nibble", nib, 4'ha);
    @(posedge clk);
    #1;
    chk("mii idle", nib_v, 1'b0);
    bus_rd(8'h74, d);
    chk("last nibble", d[3:0], 4'ha);
    bus_rd(8'h6c, d);
    chk("tx start status", d[`IRQ_TX_START], 1'b1);
    @(posedge clk);
    rmii <= 1'b1;
    i_mac.send(4'h6);
    #1;
    chk("rmii valid", nib_v, 1'b1);
    chk("rmii nibble", nib, 4'h6);
    chk("col oe_n rmii", col_oe_n, 1'b1);
    $display("transmit test done");
  endtask : t_tx

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    t_strap();
    t_irq();
    t_led();
    t_tx();
    wrap_up();
  end

  // whole run is under two hundred cycles; this is far beyond it
  initial begin
    #100000;
    error_cnt++;
    $display("watchdog expired");
    wrap_up();
  end
endmodule : tb
